// *** pttc_timer.sv ***
/*
 * Pin-triggered 16-bit timer: external trigger, event, window and pulse
 * width modes, with an APB register slave.
 * Assumes pin inputs synchronous to pclk and an APB4 master.
 */
// Our own choices: the placing of the registers and the APB register port.
// Function
// RULE1 - External trigger mode waits for the selected pin edge, then counts source ticks.
// RULE2 - External trigger: compare A match clears, halts counter and raises interrupt.
// RULE3 - With stop option, opposite edge before match clears and halts, no interrupt.
// RULE4 - After halt, next trigger edge restarts counting from zero.
// RULE5 - Without stop option, opposite and early trigger edges are ignored.
// RULE6 - Noise rejector drops pulses up to 4/fc, passes pulses of 12/fc.
// RULE7 - Low-speed modes bypass the rejector; source holds pulses one machine cycle.
// RULE8 - Event mode counts each selected pin edge, not source ticks.
// RULE9 - Event mode checks match at opposite edge: interrupt, clear, keep counting.
// RULE10 - Event source holds each level at least two machine cycles.
// RULE11 - Auto-capture copies count into compare B each tick; software waits a tick.
// RULE12 - Window mode counts ticks gated by pin level; match interrupts and clears.
// RULE13 - Window gate pulse should be much slower than the source clock.
// RULE14 - Software picks rising edge for high width, falling for low width.
// RULE15 - Single-edge capture: opposite edge captures, interrupts, clears; resume at trigger.
// RULE16 - Double-edge capture: opposite edge captures; trigger edge captures and clears.
// RULE17 - Software reads compare B before the next trigger edge.
// RULE18 - Single-edge capture holds counter at one until the next edge.
// RULE19 - Software discards the first pulse width capture after start.
// RULE20 - Compare value loads at first tick after upper byte write only.
// RULE21 - Entering stop mode forces the start field to zero.
// RULE22 - Counter is 16 bits, compared each tick, cleared on reset and mode clears; event mode compares at the opposite edge, pulse mode never compares.
`timescale 1ns/1ns
`default_nettype none
module pttc_timer #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_input_pin,
    input wire logic low_speed_run_mode,
    input wire logic low_speed_sleep_mode,
    input wire logic stop_mode_entry,
    output logic timer_interrupt_request
);
    import pttc_pkg::*;
    pttc_pin_if pin ();
    pttc_state_t state_reg;
    logic [8:0] ctrl_reg;
    logic [CNT_W-1:0] cnt_reg, cmp_a_reg, cmp_b_reg, sh_a_reg, sh_b_reg;
    logic pend_a_reg, pend_b_reg, phase_reg, irq_reg;
    logic [10:0] pre_reg;
    logic [31:0] prdata_reg;
    logic [1:0] start_f, cksel, mode;
    logic stop_opp, acap, single, started, tick, trig, opp, match_a, gate, cap_now, auto_cap;
    logic wr, setup, mapped;
    assign start_f = ctrl_reg[PTTC_START_LSB +: 2];
    assign cksel = ctrl_reg[PTTC_CKSEL_LSB +: 2];
    assign mode = ctrl_reg[PTTC_MODE_LSB +: 2];
    assign stop_opp = ctrl_reg[PTTC_STOPOPP_BIT];
    assign acap = ctrl_reg[PTTC_ACAP_BIT];
    assign single = ctrl_reg[PTTC_MCAP_BIT];
    assign started = start_f == PTTC_START_RISE || start_f == PTTC_START_FALL;
    // ------------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------------
    assign pin.pin_raw = timer_input_pin;
    assign pin.bypass = low_speed_run_mode || low_speed_sleep_mode; // RULE7
    assign pin.clk_en = clk_en;
    pttc_noise_rej u_rej (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pin.filt)
    );
    assign trig = start_f == PTTC_START_FALL ? pin.fall : pin.rise;
    assign opp = start_f == PTTC_START_FALL ? pin.rise : pin.fall;
    assign gate = pin.level == (start_f == PTTC_START_RISE);
    assign match_a = cnt_reg == cmp_a_reg;
    // ------------------------------------------------------------------
    // Source clock prescaler
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 11'h000;
        end else if (clk_en) begin
            pre_reg <= pre_reg + 11'h001;
        end
    end
    always_comb begin
        case (cksel)
            2'h0: tick = &pre_reg[PTTC_DIV0_LOG2-1:0];
            2'h1: tick = &pre_reg[PTTC_DIV1_LOG2-1:0];
            2'h2: tick = &pre_reg[PTTC_DIV2_LOG2-1:0];
            default: tick = 1'b1;
        endcase
    end
    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    always_comb begin
        if (paddr == PTTC_CTRL_OFS) begin
            mapped = 1'b1;
        end else if (paddr == PTTC_CMPA_OFS) begin
            mapped = 1'b1;
        end else if (paddr == PTTC_CMPB_OFS) begin
            mapped = 1'b1;
        end else if (paddr == PTTC_STAT_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (clk_en && setup) begin
            if (paddr == PTTC_CTRL_OFS) begin
                prdata_reg <= {23'h000000, ctrl_reg};
            end else if (paddr == PTTC_CMPA_OFS) begin
                prdata_reg <= {16'h0000, cmp_a_reg};
            end else if (paddr == PTTC_CMPB_OFS) begin
                prdata_reg <= {16'h0000, cmp_b_reg};
            end else if (paddr == PTTC_STAT_OFS) begin
                prdata_reg <= {13'h0000, pin.level, pend_a_reg, state_reg != ST_HALT, cnt_reg};
            end else begin
                prdata_reg <= 32'h00000000;
            end
        end
    end
    assign prdata = prdata_reg;
    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= PTTC_CTRL_RST;
        end else if (clk_en) begin
            if (wr && paddr == PTTC_CTRL_OFS) begin
                if (pstrb[0]) ctrl_reg[7:0] <= pwdata[7:0];
                if (pstrb[1]) ctrl_reg[8] <= pwdata[8];
            end
            if (stop_mode_entry) begin
                ctrl_reg[PTTC_START_LSB +: 2] <= PTTC_START_STOP; // RULE21
            end
        end
    end
    // ------------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_a_reg <= PTTC_CMPA_RST;
            cmp_a_reg <= PTTC_CMPA_RST;
            pend_a_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr && paddr == PTTC_CMPA_OFS && pstrb[0]) sh_a_reg[7:0] <= pwdata[7:0];
            if (wr && paddr == PTTC_CMPA_OFS && pstrb[1]) begin
                sh_a_reg[15:8] <= pwdata[15:8];
                pend_a_reg <= 1'b1; // RULE20
            end else if (tick && pend_a_reg) begin
                cmp_a_reg <= sh_a_reg; // RULE20
                pend_a_reg <= 1'b0;
            end
        end
    end
    assign auto_cap = acap && tick && state_reg == ST_RUN && mode != PTTC_MODE_PULSE;
    always_comb begin
        cap_now = 1'b0;
        if (started && mode == PTTC_MODE_PULSE && state_reg == ST_RUN) begin
            if (single) begin
                cap_now = opp;
            end else begin
                cap_now = phase_reg ? trig : opp;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_b_reg <= PTTC_CMPB_RST;
            cmp_b_reg <= PTTC_CMPB_RST;
            pend_b_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr && paddr == PTTC_CMPB_OFS && pstrb[0]) sh_b_reg[7:0] <= pwdata[7:0];
            if (wr && paddr == PTTC_CMPB_OFS && pstrb[1]) begin
                sh_b_reg[15:8] <= pwdata[15:8];
                pend_b_reg <= 1'b1; // RULE20
            end else if (tick && pend_b_reg && !cap_now && !auto_cap) begin
                pend_b_reg <= 1'b0;
            end
            if (cap_now) begin
                cmp_b_reg <= cnt_reg; // RULE15 RULE16
            end else if (auto_cap) begin
                cmp_b_reg <= cnt_reg; // RULE11
            end else if (tick && pend_b_reg) begin
                cmp_b_reg <= sh_b_reg; // RULE20
            end
        end
    end
    // ------------------------------------------------------------------
    // Counter and mode sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_HALT;
            cnt_reg <= '0; // RULE22
            phase_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= 1'b0;
            if (!started) begin
                state_reg <= ST_HALT;
                cnt_reg <= '0; // RULE22
                phase_reg <= 1'b0;
            end else begin
                case (mode)
                    PTTC_MODE_EXT: begin
                        case (state_reg)
                            ST_RUN: begin
                                if (tick && match_a) begin
                                    cnt_reg <= '0; // RULE2
                                    state_reg <= ST_HALT;
                                    irq_reg <= 1'b1;
                                end else if (opp && stop_opp) begin
                                    cnt_reg <= '0; // RULE3
                                    state_reg <= ST_HALT;
                                end else if (tick) begin
                                    cnt_reg <= cnt_reg + 1'b1; // RULE5
                                end
                            end
                            default: begin
                                if (trig) begin
                                    state_reg <= ST_RUN; // RULE1 RULE4
                                    cnt_reg <= '0;
                                end
                            end
                        endcase
                    end
                    PTTC_MODE_EVENT: begin
                        state_reg <= ST_RUN;
                        if (opp && match_a) begin
                            cnt_reg <= '0; // RULE9
                            irq_reg <= 1'b1;
                        end else if (trig) begin
                            cnt_reg <= cnt_reg + 1'b1; // RULE8
                        end
                    end
                    PTTC_MODE_WINDOW: begin
                        state_reg <= ST_RUN;
                        if (tick && gate) begin
                            if (match_a) begin
                                cnt_reg <= '0; // RULE12
                                irq_reg <= 1'b1;
                            end else begin
                                cnt_reg <= cnt_reg + 1'b1; // RULE12
                            end
                        end
                    end
                    default: begin
                        case (state_reg)
                            ST_RUN: begin
                                if (cap_now) begin
                                    irq_reg <= 1'b1;
                                    if (single) begin
                                        cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}; // RULE15 RULE18
                                        state_reg <= ST_HOLD;
                                    end else if (phase_reg) begin
                                        cnt_reg <= '0; // RULE16
                                        phase_reg <= 1'b0;
                                    end else begin
                                        phase_reg <= 1'b1; // RULE16
                                        if (tick) cnt_reg <= cnt_reg + 1'b1;
                                    end
                                end else if (tick) begin
                                    cnt_reg <= cnt_reg + 1'b1;
                                end
                            end
                            ST_HOLD: begin
                                if (trig) state_reg <= ST_RUN; // RULE18
                            end
                            default: begin
                                if (trig) begin
                                    state_reg <= ST_RUN;
                                    cnt_reg <= '0;
                                    phase_reg <= 1'b0;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end
    assign timer_interrupt_request = irq_reg;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ext_start;
        clk_en && started && mode == PTTC_MODE_EXT && state_reg == ST_HALT && trig
        |=> state_reg == ST_RUN && cnt_reg == '0;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("no start on trigger"); // RULE1
    property p_ext_match;
        clk_en && started && mode == PTTC_MODE_EXT && state_reg == ST_RUN && tick && match_a
        |=> irq_reg && state_reg == ST_HALT && cnt_reg == '0 ##1 !irq_reg;
    endproperty
    a_ext_match: assert property (p_ext_match) else $error("match not handled"); // RULE2
    property p_ext_opp;
        clk_en && started && mode == PTTC_MODE_EXT && state_reg == ST_RUN && stop_opp && opp
        && !(tick && match_a) |=> !irq_reg && state_reg == ST_HALT && cnt_reg == '0;
    endproperty
    a_ext_opp: assert property (p_ext_opp) else $error("opposite edge mishandled"); // RULE3
    property p_ext_ignore;
        clk_en && started && mode == PTTC_MODE_EXT && state_reg == ST_RUN && !stop_opp && !tick
        && (opp || trig) |=> state_reg == ST_RUN && cnt_reg == $past(cnt_reg);
    endproperty
    a_ext_ignore: assert property (p_ext_ignore) else $error("edge not ignored"); // RULE5
    property p_event_count;
        clk_en && started && mode == PTTC_MODE_EVENT && trig |=> cnt_reg == $past(cnt_reg) + 1'b1;
    endproperty
    a_event_count: assert property (p_event_count) else $error("event not counted"); // RULE8
    property p_event_match;
        clk_en && started && mode == PTTC_MODE_EVENT && opp && match_a
        |=> timer_interrupt_request && cnt_reg == '0;
    endproperty
    a_event_match: assert property (p_event_match) else $error("event match missed"); // RULE9
    property p_window;
        clk_en && started && mode == PTTC_MODE_WINDOW && tick && !gate
        |=> cnt_reg == $past(cnt_reg) && !timer_interrupt_request;
    endproperty
    a_window: assert property (p_window) else $error("counted outside window"); // RULE12
    property p_single_cap;
        clk_en && cap_now && single |=> cmp_b_reg == $past(cnt_reg) && timer_interrupt_request
        && cnt_reg == 16'h0001 && state_reg == ST_HOLD;
    endproperty
    a_single_cap: assert property (p_single_cap) else $error("single capture wrong"); // RULE15
    property p_double_cap;
        clk_en && cap_now && !single && phase_reg |=> cmp_b_reg == $past(cnt_reg)
        && timer_interrupt_request && cnt_reg == '0 && state_reg == ST_RUN;
    endproperty
    a_double_cap: assert property (p_double_cap) else $error("double capture wrong"); // RULE16
    property p_stop_entry;
        clk_en && stop_mode_entry |=> start_f == PTTC_START_STOP ##1 state_reg == ST_HALT;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop entry ignored"); // RULE21
    property p_cmp_load;
        clk_en && !pend_a_reg && !(wr && paddr == PTTC_CMPA_OFS && pstrb[1])
        |=> cmp_a_reg == $past(cmp_a_reg);
    endproperty
    a_cmp_load: assert property (p_cmp_load) else $error("compare changed early"); // RULE20
    c_ext_irq: cover property (mode == PTTC_MODE_EXT && timer_interrupt_request);
    c_event_irq: cover property (mode == PTTC_MODE_EVENT && timer_interrupt_request);
    c_window_irq: cover property (mode == PTTC_MODE_WINDOW && timer_interrupt_request);
    c_pulse_hold: cover property (state_reg == ST_HOLD ##1 state_reg == ST_RUN);
endmodule : pttc_timer
`default_nettype wire

// *** pttc_pkg.sv ***
/*
 * Shared constants and types of the pin-triggered timer with capture modes.
 * Assumes a 50 MHz APB clock that also stands for the high-frequency clock.
 */
`default_nettype none
package pttc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PTTC_CTRL_OFS = 12'h000;
    localparam logic [11:0] PTTC_CMPA_OFS = 12'h004;
    localparam logic [11:0] PTTC_CMPB_OFS = 12'h008;
    localparam logic [11:0] PTTC_STAT_OFS = 12'h00c;
    localparam logic [8:0] PTTC_CTRL_RST = 9'h000;
    localparam logic [15:0] PTTC_CMPA_RST = 16'hffff;
    localparam logic [15:0] PTTC_CMPB_RST = 16'h0000;
    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int PTTC_START_LSB = 0;
    localparam int PTTC_CKSEL_LSB = 2;
    localparam int PTTC_MODE_LSB = 4;
    localparam int PTTC_STOPOPP_BIT = 6;
    localparam int PTTC_ACAP_BIT = 7;
    localparam int PTTC_MCAP_BIT = 8;
    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PTTC_START_STOP = 2'h0;
    localparam logic [1:0] PTTC_START_RISE = 2'h2;
    localparam logic [1:0] PTTC_START_FALL = 2'h3;
    localparam logic [1:0] PTTC_MODE_EXT = 2'h0;
    localparam logic [1:0] PTTC_MODE_EVENT = 2'h1;
    localparam logic [1:0] PTTC_MODE_WINDOW = 2'h2;
    localparam logic [1:0] PTTC_MODE_PULSE = 2'h3;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PTTC_DIV0_LOG2 = 11;
    localparam int PTTC_DIV1_LOG2 = 7;
    localparam int PTTC_DIV2_LOG2 = 3;
    localparam int PTTC_NR_REJECT_FC = 4;
    localparam int PTTC_NR_GUAR_FC = 12;
    localparam int PTTC_NR_ACCEPT_CYC = PTTC_NR_REJECT_FC + 1;
    typedef enum logic [2:0] {
        ST_HALT = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } pttc_state_t;
endpackage : pttc_pkg
`default_nettype wire

// *** pttc_pin_if.sv ***
/*
 * Carrier between the timer core and its input noise rejector.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ns
`default_nettype none
interface pttc_pin_if;
    logic pin_raw;
    logic bypass;
    logic clk_en;
    logic level;
    logic rise;
    logic fall;
    modport filt (input pin_raw, input bypass, input clk_en, output level, output rise,
                  output fall);
    modport core (output pin_raw, output bypass, output clk_en, input level, input rise,
                  input fall);
endinterface : pttc_pin_if
`default_nettype wire

// *** pttc_noise_rej.sv ***
/*
 * Input noise rejector and edge detector for the timer input pin.
 * Assumes the pin is synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none
module pttc_noise_rej (
    input wire logic pclk,
    input wire logic presetn,
    pttc_pin_if.filt pin
);
    import pttc_pkg::*;
    logic level_reg;
    logic [3:0] run_reg;
    logic changed;
    assign changed = pin.pin_raw != level_reg;
    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= 1'b0;
            run_reg <= 4'h0;
        end else if (pin.clk_en) begin
            if (pin.bypass) begin
                level_reg <= pin.pin_raw; // RULE7
                run_reg <= 4'h0;
            end else if (!changed) begin
                run_reg <= 4'h0;
            end else if (run_reg == 4'(PTTC_NR_ACCEPT_CYC - 1)) begin
                level_reg <= pin.pin_raw; // RULE6
                run_reg <= 4'h0;
            end else begin
                run_reg <= run_reg + 4'h1; // RULE6
            end
        end
    end
    assign pin.level = level_reg;
    assign pin.rise = pin.clk_en && !level_reg &&
        (pin.bypass ? pin.pin_raw : changed && run_reg == 4'(PTTC_NR_ACCEPT_CYC - 1));
    assign pin.fall = pin.clk_en && level_reg &&
        (pin.bypass ? !pin.pin_raw : changed && run_reg == 4'(PTTC_NR_ACCEPT_CYC - 1));
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_reject_short;
        @(posedge pclk) disable iff (!presetn)
        pin.clk_en && !pin.bypass && changed && run_reg < 4'(PTTC_NR_ACCEPT_CYC - 1)
        |=> level_reg == $past(level_reg);
    endproperty
    a_reject_short: assert property (p_reject_short) else $error("short pulse passed"); // RULE6
endmodule : pttc_noise_rej
`default_nettype wire

// *** pttc_pin_src.sv ***
/* Behavioural model of the external pulse source on the timer input pin.
   Assumes the bench calls its task right after a rising pclk edge. */
`timescale 1ns/1ns
`default_nettype none
module pttc_pin_src (
    input wire logic pclk,
    output logic pin
);
    initial pin = 1'b0;
    // Every level is held for the given cycles, kept well above the filter span.
    task automatic pulse(input int hi, input int lo);
        pin <= 1'b1;
        repeat (hi) @(posedge pclk);
        pin <= 1'b0;
        repeat (lo) @(posedge pclk);
    endtask : pulse
endmodule : pttc_pin_src
`default_nettype wire

// *** tb_top.sv ***
/* Self-checking bench of the pin-triggered timer with an APB master.
   Assumes pttc_pkg, the timer, its filter and the pin source are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pttc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic lsm = 1'b0, stp = 1'b0, pready, pslverr, irq, pin, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, c1 = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [63:0] exp_q[$];
    logic [63:0] ev;
    logic [7:0] lf = 8'h45;
    int bad_count = 0, n_compared = 0, n_irq = 0, cyc = 0, w;
    always #10 pclk = ~pclk;
    pttc_pin_src src (.pclk(pclk), .pin(pin));
    pttc_timer DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(pin),
        .low_speed_run_mode(lsm), .low_speed_sleep_mode(lsm), .stop_mode_entry(stp),
        .timer_interrupt_request(irq));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic results;
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        apb(1'b0, a, 32'h0, 4'h0);
    endtask : rd
    always @(posedge pclk) begin
        cyc++;
        if (irq === 1'b1) n_irq++;
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
            ev = exp_q.pop_front();
            check(prdata & ev[63:32], ev[31:0]);
        end
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(PTTC_CTRL_OFS, 32'h0, 32'h1ff);
        rd(PTTC_CMPA_OFS, 32'hffff, 32'hffff);
        rd(PTTC_CMPB_OFS, 32'h0, 32'hffff);
        rd(PTTC_STAT_OFS, 32'h0, 32'hffff);
        rd(12'h010, 32'h0, 32'hffffffff);
        check({31'h0, err}, 32'h1);
        apb(1'b1, PTTC_CTRL_OFS, 32'h04c, 4'h3);
        apb(1'b1, PTTC_CMPA_OFS, 32'h40, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h04e, 4'h3);
        src.pulse(12, 10);
        rd(PTTC_STAT_OFS, 32'h0, 32'hffff);
        apb(1'b1, PTTC_CTRL_OFS, 32'h008, 4'h3);
        apb(1'b1, PTTC_CMPA_OFS, 32'h2, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h00a, 4'h3);
        src.pulse(12, 20);
        src.pulse(12, 20);
        check(n_irq, 32'h2);
        lsm <= 1'b1;
        apb(1'b1, PTTC_CTRL_OFS, 32'h01c, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h01e, 4'h3);
        for (int i = 0; i < 3; i++) begin
            lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            src.pulse(8 + lf[2:0], 8 + lf[5:3]);
        end
        rd(PTTC_STAT_OFS, 32'h1, 32'hffff);
        check(n_irq, 32'h3);
        lsm <= 1'b0;
        w = 10 + lf[3:0];
        apb(1'b1, PTTC_CTRL_OFS, 32'h13c, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h13e, 4'h3);
        for (int i = 0; i < 3; i++) begin
            src.pulse(w, 8);
            rd(PTTC_CMPB_OFS, c1 + 32'h1, (i == 0) ? 32'h0 : 32'hffff);
            if (i == 0) c1 = r;
        end
        check(n_irq, 32'h6);
        apb(1'b1, PTTC_CTRL_OFS, 32'h03c, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h03e, 4'h3);
        src.pulse(w, 8);
        src.pulse(w, 8);
        rd(PTTC_CMPB_OFS, w - 1, 32'hffff);
        apb(1'b1, PTTC_CTRL_OFS, 32'h0ac, 4'h3);
        apb(1'b1, PTTC_CTRL_OFS, 32'h0ae, 4'h3);
        src.pulse(11, 8);
        rd(PTTC_STAT_OFS, 32'h2, 32'hffff);
        rd(PTTC_CMPB_OFS, 32'h2, 32'hffff);
        check(n_irq, 32'hc);
        apb(1'b1, PTTC_CTRL_OFS, 32'h00c, 4'h3);
        apb(1'b1, PTTC_CMPA_OFS, 32'h0055, 4'h1);
        rd(PTTC_CMPA_OFS, 32'h2, 32'hffff);
        apb(1'b1, PTTC_CMPA_OFS, 32'h3300, 4'h2);
        rd(PTTC_CMPA_OFS, 32'h3355, 32'hffff);
        apb(1'b1, PTTC_CTRL_OFS, 32'h00e, 4'h3);
        @(posedge pclk);
        stp <= 1'b1;
        @(posedge pclk);
        stp <= 1'b0;
        rd(PTTC_CTRL_OFS, 32'h00c, 32'h1ff);
        results();
    end
endmodule : tb_top
`default_nettype wire
